// *** bench/mcu_port_pullup_io_bench.sv ***
module mcu_port_pullup_io_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import gpio_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        warm_reset_i = 1'b0;
    logic        ce_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0000_0000;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        powered_down_o;
    logic        wake_o;
    byte_t       pin_in [3];
    byte_t       pin_out [3];
    byte_t       oe_n [3];
    byte_t       pull [3];
    byte_t       drv_en [3] = '{8'h00, 8'h00, 8'h00};
    byte_t       drv_val [3] = '{8'h00, 8'h00, 8'h00};
    int          n_mismatch = 0;
    int          checked = 0;
    int          cycles = 0;

    always #20 clk_i = ~clk_i;

    mcu_port_pullup_io DUT (
        .clk_i(clk_i), .rst_i(rst_i), .warm_reset_i(warm_reset_i),
        .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
        .ack_o(ack_o), .port_a_pin_i(pin_in[0]), .port_a_pin_o(pin_out[0]),
        .port_a_oe_n_o(oe_n[0]), .port_a_pullup_o(pull[0]),
        .port_b_pin_i(pin_in[1]), .port_b_pin_o(pin_out[1]),
        .port_b_oe_n_o(oe_n[1]), .port_b_pullup_o(pull[1]),
        .port_c_pin_i(pin_in[2]), .port_c_pin_o(pin_out[2]),
        .port_c_oe_n_o(oe_n[2]), .port_c_pullup_o(pull[2]),
        .powered_down_o(powered_down_o), .wake_o(wake_o)
    );
    for (genvar k = 0; k < 3; k++) begin : g_pin
        pin_model u_pin (
            .clk_i(clk_i), .out_i(pin_out[k]), .oe_n_i(oe_n[k]),
            .pullup_i(pull[k]), .drv_en_i(drv_en[k]),
            .drv_val_i(drv_val[k]), .level_o(pin_in[k])
        );
    end

    // ************************************************************
    // Bus and checking tasks
    // ************************************************************
    task automatic end_of_test();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input byte_t d,
                       output byte_t q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        sel_i <= 4'h1;
        dat_i <= {PAD_ZERO, d};
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o[7:0];
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input byte_t d);
        byte_t q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input byte_t exp);
        byte_t q;
        bus(1'b0, a, 8'h00, q);
        check(q, exp);
    endtask
    task automatic do_reset(input logic warm);
        warm_reset_i <= warm;
        rst_i <= 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        warm_reset_i <= 1'b0;
        @(posedge clk_i);
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    // ************************************************************
    // Tests
    // ************************************************************
    initial begin
        int n;
        do_reset(1'b0);
        rd(OFF_PORT_A_DIRECTION, 8'hff);
        rd(OFF_PORT_B_DIRECTION, 8'h3f);
        rd(OFF_PORT_C_DIRECTION, 8'hff);
        rd(OFF_PORT_A_PULLUP, 8'h00);
        rd(OFF_PORT_B_PULLUP, 8'h00);
        rd(OFF_PORT_C_PULLUP, 8'hff);
        rd(OFF_PORT_A_WAKE, 8'h00);
        rd(8'h3c, 8'h00);
        check(pull[2], 8'hff);
        $display("test reset values done");
        wr(OFF_PORT_A_PULLUP, 8'hff);
        wr(OFF_PORT_B_PULLUP, 8'hff);
        rd(OFF_PORT_A_PULLUP, 8'h7f);
        rd(OFF_PORT_B_PULLUP, 8'h3f);
        check(pull[0], 8'h7f);
        wr(OFF_PORT_A_DIRECTION, 8'h0f);
        wr(OFF_PORT_C_DIRECTION, 8'hf0);
        check(pull[0], 8'h0f);
        check(pull[2], 8'hf0);
        check(oe_n[0], 8'h0f);
        wr(OFF_PORT_C_PULLUP, 8'h00);
        check(pull[2], 8'h00);
        $display("test pull-ups done");
        drv_en[0] <= 8'hff;
        drv_val[0] <= 8'ha5;
        wr(OFF_PORT_A_DATA, 8'h5a);
        check(pin_out[0], 8'h5a);
        rd(OFF_PORT_A_DATA, 8'h55);
        drv_val[0] <= 8'h3c;
        rd(OFF_PORT_A_DATA, 8'h5c);
        wr(OFF_PORT_A_DIRECTION, 8'h00);
        check(oe_n[0], 8'h00);
        rd(OFF_PORT_A_DATA, 8'h5a);
        wr(OFF_PORT_A_DIRECTION, 8'hff);
        rd(OFF_PORT_A_DATA, 8'h3c);
        check(pin_out[0], 8'h5a);
        wr(OFF_PORT_B_DIRECTION, 8'h00);
        check(oe_n[1], 8'hc0);
        check(pull[1], 8'h00);
        wr(OFF_PORT_B_DATA, 8'hff);
        check(pin_out[1], 8'hff);
        rd(OFF_PORT_B_DATA, 8'h3f);
        wr(OFF_PORT_C_DATA, 8'h96);
        check(pin_out[2], 8'h96);
        ce_i <= 1'b0;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= 1'b1;
        adr_i <= OFF_PORT_A_DATA;
        dat_i <= 32'h0000_0000;
        repeat (4) @(posedge clk_i);
        check(ack_o, 1'b0);
        check(pin_out[0], 8'h5a);
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        ce_i <= 1'b1;
        @(posedge clk_i);
        $display("test data paths done");
        drv_val[0] <= 8'h3d;
        wr(OFF_PORT_A_WAKE, 8'h01);
        wr(OFF_POWER_CONTROL, 8'h01);
        check(powered_down_o, 1'b1);
        drv_val[0] <= 8'h39;
        repeat (3) @(posedge clk_i);
        check(powered_down_o, 1'b1);
        drv_val[0] <= 8'h38;
        n = 0;
        while (wake_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        check(wake_o, 1'b1);
        check(powered_down_o, 1'b0);
        rd(OFF_WAKE_STATUS, 8'h01);
        rd(OFF_POWER_CONTROL, 8'h00);
        wr(OFF_WAKE_STATUS, 8'h01);
        rd(OFF_WAKE_STATUS, 8'h00);
        wr(OFF_POWER_CONTROL, 8'h01);
        rd(OFF_WAKE_STATUS, 8'h02);
        wr(OFF_POWER_CONTROL, 8'h00);
        check(powered_down_o, 1'b0);
        $display("test wake done");
        do_reset(1'b1);
        rd(OFF_PORT_C_DIRECTION, 8'hf0);
        rd(OFF_PORT_A_WAKE, 8'h01);
        check(pin_out[0], 8'h5a);
        do_reset(1'b0);
        rd(OFF_PORT_C_DIRECTION, 8'hff);
        rd(OFF_PORT_A_WAKE, 8'h00);
        check(pull[2], 8'hff);
        $display("test resets done");
        end_of_test();
    end
endmodule

// *** bench/pin_model.sv ***
module pin_model (
    input  wire logic            clk_i,
    input  wire gpio_pkg::byte_t out_i,
    input  wire gpio_pkg::byte_t oe_n_i,
    input  wire gpio_pkg::byte_t pullup_i,
    input  wire gpio_pkg::byte_t drv_en_i,
    input  wire gpio_pkg::byte_t drv_val_i,
    output gpio_pkg::byte_t      level_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import gpio_pkg::*;
    byte_t float_q = 8'h55;

    // Undriven pins without pull-up wander every cycle
    always_ff @(posedge clk_i) begin
        float_q <= ~float_q;
    end
    assign level_o = (~oe_n_i & out_i) | (oe_n_i & drv_en_i & drv_val_i)
                   | (oe_n_i & ~drv_en_i & (pullup_i | float_q));
endmodule

// *** bench/port_checker_assertions.sv ***
module port_checker (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            warm_reset_i,
    input  wire logic            ce_i,
    input  wire logic            cyc_i,
    input  wire logic            stb_i,
    input  wire logic            we_i,
    input  wire logic [7:0]      adr_i,
    input  wire logic [3:0]      sel_i,
    input  wire logic [31:0]     dat_i,
    input  wire logic [31:0]     dat_o,
    input  wire logic            ack_o,
    input  wire gpio_pkg::byte_t port_a_pin_i,
    input  wire gpio_pkg::byte_t port_a_pin_o,
    input  wire gpio_pkg::byte_t port_a_oe_n_o,
    input  wire gpio_pkg::byte_t port_a_pullup_o,
    input  wire gpio_pkg::byte_t port_b_pullup_o,
    input  wire gpio_pkg::byte_t port_c_oe_n_o,
    input  wire gpio_pkg::byte_t port_c_pullup_o,
    input  wire logic            powered_down_o,
    input  wire logic            wake_o
);
    import gpio_pkg::*;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_take;
        cyc_i && stb_i && !ack_o && ce_i;
    endsequence
    sequence s_write(logic [7:0] a);
        s_take ##0 (we_i && sel_i[0] && adr_i == a);
    endsequence
    sequence s_pulse;
        ack_o ##1 !ack_o;
    endsequence

    property p_ack_once;
        s_take |=> s_pulse;
    endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("ack not a single pulse");
    property p_dat_idle;
        !ack_o |-> dat_o == BUS_ZERO;
    endproperty
    a_dat_idle: assert property (p_dat_idle)
        else $error("read data not zero outside ack");
    property p_dir_write;
        s_write(OFF_PORT_A_DIRECTION) |=> port_a_oe_n_o == $past(dat_i[7:0]);
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("direction write not applied");
    property p_latch_hold;
        !(cyc_i && stb_i && we_i && adr_i == OFF_PORT_A_DATA)
            |=> $stable(port_a_pin_o);
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("output latch changed without a write");
    property p_read_live;
        s_take ##0 (!we_i && adr_i == OFF_PORT_A_DATA) |=> dat_o[7:0] ==
            (($past(port_a_oe_n_o) & $past(port_a_pin_i)) |
             (~$past(port_a_oe_n_o) & $past(port_a_pin_o)));
    endproperty
    a_read_live: assert property (p_read_live)
        else $error("port read mixes pins and latch wrongly");
    property p_pull_input;
        ((port_a_pullup_o & ~$past(port_a_oe_n_o)) |
         (port_c_pullup_o & ~$past(port_c_oe_n_o))) == 8'h00;
    endproperty
    a_pull_input: assert property (p_pull_input)
        else $error("pull-up active on an output pin");
    property p_no_pull_bits;
        port_a_pullup_o[7] == 1'b0 && port_b_pullup_o[7:6] == 2'b00;
    endproperty
    a_no_pull_bits: assert property (p_no_pull_bits)
        else $error("pull-up on a pin without one");
    property p_cold_values;
        $past(rst_i) && !$past(warm_reset_i) |-> port_a_oe_n_o == DIR_RST
            && port_a_pullup_o == PORT_A_PU_RST
            && port_c_pullup_o == PORT_C_PU_RST;
    endproperty
    a_cold_values: assert property (p_cold_values)
        else $error("wrong state after cold reset");
    property p_wake;
        wake_o |-> !powered_down_o && $past(powered_down_o)
            && |($past(port_a_pin_i, 2) & ~$past(port_a_pin_i));
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake without falling pin in power-down");
endmodule

bind mcu_port_pullup_io port_checker u_chk (
    .clk_i, .rst_i, .warm_reset_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .port_a_pin_i, .port_a_pin_o,
    .port_a_oe_n_o, .port_a_pullup_o, .port_b_pullup_o, .port_c_oe_n_o,
    .port_c_pullup_o, .powered_down_o, .wake_o
);

// *** rtl/gpio_pkg.sv ***
package gpio_pkg;

    typedef logic [7:0] byte_t;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFF_PORT_A_DATA      = 8'h00;
    localparam logic [7:0] OFF_PORT_A_DIRECTION = 8'h04;
    localparam logic [7:0] OFF_PORT_A_PULLUP    = 8'h08;
    localparam logic [7:0] OFF_PORT_A_WAKE      = 8'h0c;
    localparam logic [7:0] OFF_PORT_B_DATA      = 8'h10;
    localparam logic [7:0] OFF_PORT_B_DIRECTION = 8'h14;
    localparam logic [7:0] OFF_PORT_B_PULLUP    = 8'h18;
    localparam logic [7:0] OFF_PORT_C_DATA      = 8'h20;
    localparam logic [7:0] OFF_PORT_C_DIRECTION = 8'h24;
    localparam logic [7:0] OFF_PORT_C_PULLUP    = 8'h28;
    localparam logic [7:0] OFF_POWER_CONTROL    = 8'h30;
    localparam logic [7:0] OFF_WAKE_STATUS      = 8'h34;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int BIT_POWER_DOWN   = 0;
    localparam int BIT_WAKE_SEEN    = 0;
    localparam int BIT_STAT_PDOWN   = 1;

    // ************************************************************
    // Implemented bits and reset values
    // ************************************************************
    localparam byte_t PORT_A_IMPL   = 8'hff;
    localparam byte_t PORT_B_IMPL   = 8'h3f;
    localparam byte_t PORT_C_IMPL   = 8'hff;
    localparam byte_t PORT_A_PU_IMPL = 8'h7f;
    localparam byte_t PORT_B_PU_IMPL = 8'h3f;
    localparam byte_t PORT_C_PU_IMPL = 8'hff;

    localparam byte_t DATA_RST      = 8'hff;
    localparam byte_t DIR_RST       = 8'hff;
    localparam byte_t PORT_A_PU_RST = 8'h00;
    localparam byte_t PORT_B_PU_RST = 8'h00;
    localparam byte_t PORT_C_PU_RST = 8'hff;
    localparam byte_t WAKE_RST      = 8'h00;

    localparam logic [31:0] BUS_ZERO = 32'h0000_0000;
    localparam logic [23:0] PAD_ZERO = 24'h00_0000;

    // ************************************************************
    // Helpers
    // ************************************************************
    // Input pins show the live level, output pins the latch
    function automatic byte_t port_read(input byte_t dir,
                                        input byte_t latch,
                                        input byte_t pin);
        port_read = (dir & pin) | (~dir & latch);
    endfunction

    function automatic byte_t gate(input logic sel, input byte_t val);
        gate = {8{sel}} & val;
    endfunction

endpackage

// *** rtl/mcu_port_pullup_io.sv ***
module mcu_port_pullup_io (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             warm_reset_i,
    input  wire logic             ce_i,
    // Wishbone slave
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [7:0]       adr_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic [31:0]      dat_i,
    output logic      [31:0]      dat_o,
    output logic                  ack_o,
    // Port A
    input  wire gpio_pkg::byte_t  port_a_pin_i,
    output gpio_pkg::byte_t       port_a_pin_o,
    output gpio_pkg::byte_t       port_a_oe_n_o,
    output gpio_pkg::byte_t       port_a_pullup_o,
    // Port B
    input  wire gpio_pkg::byte_t  port_b_pin_i,
    output gpio_pkg::byte_t       port_b_pin_o,
    output gpio_pkg::byte_t       port_b_oe_n_o,
    output gpio_pkg::byte_t       port_b_pullup_o,
    // Port C
    input  wire gpio_pkg::byte_t  port_c_pin_i,
    output gpio_pkg::byte_t       port_c_pin_o,
    output gpio_pkg::byte_t       port_c_oe_n_o,
    output gpio_pkg::byte_t       port_c_pullup_o,
    // Power-down and wake
    output logic                  powered_down_o,
    output logic                  wake_o
);
    import gpio_pkg::*;

    // ************************************************************
    // Bus decode
    // ************************************************************
    logic        ack_q;
    logic [31:0] dat_q;

    wire logic  req      = cyc_i & stb_i & ~ack_q;
    wire logic  wr_req   = req & we_i & sel_i[0];
    wire logic  rd_req   = req & ~we_i;
    wire byte_t wbyte    = dat_i[7:0];

    wire logic hit_a_data = (adr_i == OFF_PORT_A_DATA);
    wire logic hit_a_dir  = (adr_i == OFF_PORT_A_DIRECTION);
    wire logic hit_a_pu   = (adr_i == OFF_PORT_A_PULLUP);
    wire logic hit_a_wake = (adr_i == OFF_PORT_A_WAKE);
    wire logic hit_b_data = (adr_i == OFF_PORT_B_DATA);
    wire logic hit_b_dir  = (adr_i == OFF_PORT_B_DIRECTION);
    wire logic hit_b_pu   = (adr_i == OFF_PORT_B_PULLUP);
    wire logic hit_c_data = (adr_i == OFF_PORT_C_DATA);
    wire logic hit_c_dir  = (adr_i == OFF_PORT_C_DIRECTION);
    wire logic hit_c_pu   = (adr_i == OFF_PORT_C_PULLUP);
    wire logic hit_pctl   = (adr_i == OFF_POWER_CONTROL);
    wire logic hit_stat   = (adr_i == OFF_WAKE_STATUS);

    wire logic we_a_data = wr_req & hit_a_data;
    wire logic we_a_dir  = wr_req & hit_a_dir;
    wire logic we_a_pu   = wr_req & hit_a_pu;
    wire logic we_a_wake = wr_req & hit_a_wake;
    wire logic we_b_data = wr_req & hit_b_data;
    wire logic we_b_dir  = wr_req & hit_b_dir;
    wire logic we_b_pu   = wr_req & hit_b_pu;
    wire logic we_c_data = wr_req & hit_c_data;
    wire logic we_c_dir  = wr_req & hit_c_dir;
    wire logic we_c_pu   = wr_req & hit_c_pu;
    wire logic we_pctl   = wr_req & hit_pctl;
    wire logic we_stat   = wr_req & hit_stat;

    // Warm reset leaves every port register as it was
    wire logic cold_rst = rst_i & ~warm_reset_i;

    // ************************************************************
    // Port banks
    // ************************************************************
    byte_t a_data_rd;
    byte_t a_dir_rd;
    byte_t a_pu_rd;
    byte_t b_data_rd;
    byte_t b_dir_rd;
    byte_t b_pu_rd;
    byte_t c_data_rd;
    byte_t c_dir_rd;
    byte_t c_pu_rd;

    // port A pull-ups on bits 6 to 0 only
    port_bank #(
        .IMPL    (PORT_A_IMPL),
        .PU_IMPL (PORT_A_PU_IMPL),
        .PU_RST  (PORT_A_PU_RST)
    ) u_port_a (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .keep_i    (warm_reset_i),
        .ce_i      (ce_i),
        .wdata_i   (wbyte),
        .data_we_i (we_a_data),
        .dir_we_i  (we_a_dir),
        .pu_we_i   (we_a_pu),
        .pin_i     (port_a_pin_i),
        .pin_o     (port_a_pin_o),
        .oe_n_o    (port_a_oe_n_o),
        .pullup_o  (port_a_pullup_o),
        .data_rd_o (a_data_rd),
        .dir_rd_o  (a_dir_rd),
        .pu_rd_o   (a_pu_rd)
    );

    // port B has six pins and six pull-ups
    port_bank #(
        .IMPL    (PORT_B_IMPL),
        .PU_IMPL (PORT_B_PU_IMPL),
        .PU_RST  (PORT_B_PU_RST)
    ) u_port_b (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .keep_i    (warm_reset_i),
        .ce_i      (ce_i),
        .wdata_i   (wbyte),
        .data_we_i (we_b_data),
        .dir_we_i  (we_b_dir),
        .pu_we_i   (we_b_pu),
        .pin_i     (port_b_pin_i),
        .pin_o     (port_b_pin_o),
        .oe_n_o    (port_b_oe_n_o),
        .pullup_o  (port_b_pullup_o),
        .data_rd_o (b_data_rd),
        .dir_rd_o  (b_dir_rd),
        .pu_rd_o   (b_pu_rd)
    );

    // port C pull-ups all enabled out of reset
    port_bank #(
        .IMPL    (PORT_C_IMPL),
        .PU_IMPL (PORT_C_PU_IMPL),
        .PU_RST  (PORT_C_PU_RST)
    ) u_port_c (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .keep_i    (warm_reset_i),
        .ce_i      (ce_i),
        .wdata_i   (wbyte),
        .data_we_i (we_c_data),
        .dir_we_i  (we_c_dir),
        .pu_we_i   (we_c_pu),
        .pin_i     (port_c_pin_i),
        .pin_o     (port_c_pin_o),
        .oe_n_o    (port_c_oe_n_o),
        .pullup_o  (port_c_pullup_o),
        .data_rd_o (c_data_rd),
        .dir_rd_o  (c_dir_rd),
        .pu_rd_o   (c_pu_rd)
    );

    // ************************************************************
    // Port A wake-up
    // ************************************************************
    byte_t wake_en_q;
    byte_t pa_prev_q;
    logic  power_down_q;
    logic  wake_q;
    logic  wake_seen_q;

    // falling edge on an enabled pin while powered down
    wire byte_t pa_fall  = pa_prev_q & ~port_a_pin_i & wake_en_q;
    wire logic  wake_hit = power_down_q & (|pa_fall);

    wire logic  pd_req   = we_pctl & dat_i[BIT_POWER_DOWN];
    wire logic  pd_leave = we_pctl & ~dat_i[BIT_POWER_DOWN];
    wire logic  seen_clr = we_stat & dat_i[BIT_WAKE_SEEN];

    always_ff @(posedge clk_i) begin
        if (cold_rst) begin
            // wake enables cleared on cold resets
            wake_en_q <= WAKE_RST;
        end else if (!rst_i && ce_i && we_a_wake) begin
            wake_en_q <= wbyte;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_prev_q <= DATA_RST;
        end else if (ce_i) begin
            pa_prev_q <= port_a_pin_i;
        end
    end

    // Wake wins over a request written in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            power_down_q <= 1'b0;
        end else if (ce_i) begin
            // leave power-down on a wake edge
            if (wake_hit) begin
                power_down_q <= 1'b0;
            end else if (pd_req) begin
                power_down_q <= 1'b1;
            end else if (pd_leave) begin
                power_down_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_q <= 1'b0;
        end else if (ce_i) begin
            wake_q <= wake_hit;
        end
    end

    // Sticky wake flag, set beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (cold_rst) begin
            wake_seen_q <= 1'b0;
        end else if (!rst_i && ce_i) begin
            if (wake_hit) begin
                wake_seen_q <= 1'b1;
            end else if (seen_clr) begin
                wake_seen_q <= 1'b0;
            end
        end
    end

    assign powered_down_o = power_down_q;
    assign wake_o         = wake_q;

    // ************************************************************
    // Read selection
    // ************************************************************
    wire byte_t pctl_rd = {7'h00, power_down_q};
    wire byte_t stat_rd = {6'h00, power_down_q, wake_seen_q};

    // data reads pass live pins or latches
    wire byte_t rd_byte = gate(hit_a_data, a_data_rd)
                        | gate(hit_a_dir,  a_dir_rd)
                        | gate(hit_a_pu,   a_pu_rd)
                        | gate(hit_a_wake, wake_en_q)
                        | gate(hit_b_data, b_data_rd)
                        | gate(hit_b_dir,  b_dir_rd)
                        | gate(hit_b_pu,   b_pu_rd)
                        | gate(hit_c_data, c_data_rd)
                        | gate(hit_c_dir,  c_dir_rd)
                        | gate(hit_c_pu,   c_pu_rd)
                        | gate(hit_pctl,   pctl_rd)
                        | gate(hit_stat,   stat_rd);

    wire logic [31:0] rd_word = {PAD_ZERO, rd_byte};

    // ************************************************************
    // Bus answer
    // ************************************************************
    // One wait state; unmapped offsets answer with zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else if (ce_i) begin
            ack_q <= req;
        end
    end

    // the pin level is captured on the answering edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= BUS_ZERO;
        end else if (ce_i) begin
            dat_q <= rd_req ? rd_word : BUS_ZERO;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

endmodule

// *** rtl/port_bank.sv ***
module port_bank #(
    parameter gpio_pkg::byte_t IMPL    = 8'hff,
    parameter gpio_pkg::byte_t PU_IMPL = 8'hff,
    parameter gpio_pkg::byte_t PU_RST  = 8'h00
) (
    input  wire logic            clk_i,
    input  wire logic            rst_i,
    input  wire logic            keep_i,
    input  wire logic            ce_i,
    input  wire gpio_pkg::byte_t wdata_i,
    input  wire logic            data_we_i,
    input  wire logic            dir_we_i,
    input  wire logic            pu_we_i,
    input  wire gpio_pkg::byte_t pin_i,
    output gpio_pkg::byte_t      pin_o,
    output gpio_pkg::byte_t      oe_n_o,
    output gpio_pkg::byte_t      pullup_o,
    output gpio_pkg::byte_t      data_rd_o,
    output gpio_pkg::byte_t      dir_rd_o,
    output gpio_pkg::byte_t      pu_rd_o
);
    import gpio_pkg::*;

    byte_t data_q;
    byte_t dir_q;
    byte_t pu_q;
    byte_t pull_q;

    // Absent pins stay inputs so they never drive
    wire byte_t dir_wr = wdata_i | ~IMPL;

    // ************************************************************
    // Latches
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            if (!keep_i) begin
                dir_q  <= DIR_RST;
                data_q <= DATA_RST;
                pu_q   <= PU_RST & PU_IMPL;
                pull_q <= PU_RST & PU_IMPL;
            end
        end else if (ce_i) begin
            if (data_we_i) data_q <= wdata_i;
            if (dir_we_i) dir_q <= dir_wr;
            if (pu_we_i) pu_q <= wdata_i & PU_IMPL;
            // pull-up only on enabled input pins
            pull_q <= pu_q & dir_q & PU_IMPL;
        end
    end

    // direction 1 releases the pin, 0 drives it
    assign oe_n_o   = dir_q;
    assign pin_o    = data_q;
    assign pullup_o = pull_q;

    // live pin on inputs, latch on outputs
    assign data_rd_o = port_read(dir_q, data_q, pin_i) & IMPL;
    assign dir_rd_o  = dir_q & IMPL;
    assign pu_rd_o   = pu_q;

endmodule
